// ==== design/ithr_pkg.sv ====
`default_nettype none
package ithr_pkg;
	// command codes
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h03;
	localparam logic [7:0] CMD_RESTORE_ALL  = 8'h16;
	localparam logic [7:0] CMD_TURN_ON_THR  = 8'h35;
	localparam logic [7:0] CMD_TURN_OFF_THR = 8'h36;
	localparam logic [7:0] CMD_PHASE_POS    = 8'h37;
	localparam logic [7:0] CMD_STS_INPUT    = 8'h7c;
	localparam logic [7:0] CMD_STS_CML      = 8'h7e;

	// linear word layout
	localparam int          EXP_MSB = 15;
	localparam int          EXP_LSB = 11;
	localparam int          MAN_MSB = 10;
	localparam logic [4:0]  EXP_RST = 5'h1e;

	// thresholds in quarter volts
	localparam logic signed [31:0] ON_MIN_Q  = 32'sh0000000a;
	localparam logic signed [31:0] OFF_MIN_Q = 32'sh00000009;
	localparam logic signed [31:0] THR_MAX_Q = 32'sh00000049;
	localparam logic signed [5:0]  QTR_SHIFT = 6'sh02;

	// phase position fields
	localparam int         GRP_MSB   = 11;
	localparam int         CNT_MSB   = 7;
	localparam int         SLOT_MSB  = 3;
	localparam logic [3:0] CNT_MIN   = 4'h1;
	localparam logic [3:0] CNT_MAX   = 4'h4;
	localparam logic [8:0] PH_STEP2  = 9'h0b4;
	localparam logic [8:0] PH_STEP3  = 9'h078;
	localparam logic [8:0] PH_STEP4  = 9'h05a;

	// status bit positions
	localparam int STS_LOW_OFF_BIT = 3;
	localparam int STS_UV_BIT      = 4;
	localparam int STS_INVALID_BIT = 6;

	typedef struct packed {
		logic [4:0]  exp;
		logic [10:0] man;
	} ithr_lin_s;

	typedef struct packed {
		logic [3:0] sync_group_number;
		logic [3:0] count;
		logic [3:0] slot;
	} ithr_ilv_s;

	typedef struct packed {
		logic        write;
		logic [7:0]  cmd;
		logic [15:0] wdata;
	} ithr_req_s;

	typedef struct packed {
		logic signed [31:0] q;
		logic               frac;
	} ithr_dec_s;

	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_RUN  = 2'b01
	} ithr_state_e;

	typedef struct packed {
		ithr_state_e state;
		ithr_lin_s   on_thr;
		ithr_lin_s   off_thr;
		ithr_ilv_s   ilv;
		logic        ilv_wr_ok;
		logic        mask;
		logic        conv;
		logic        sts_low_off;
		logic        sts_uv;
		logic        sts_invalid;
		logic        alert;
		logic [15:0] rdata;
		logic        req_seen;
		logic        ack_tgl;
		logic [6:0]  on_step;
		logic [6:0]  off_step;
		logic [8:0]  phase_deg;
	} ithr_sys_s;

	typedef struct packed {
		ithr_req_s   req;
		logic        req_tgl;
		logic        busy;
		logic        ack_seen;
		logic        done;
		logic [15:0] rdata;
	} ithr_link_s;
endpackage
`default_nettype wire

// ==== design/ithr_regs.sv ====
// Overview of operation
// [RQ1] thresholds hold linear words: exponent 15:11 resets to -2, mantissa from nvm
// [RQ2] out-of-range threshold writes are refused and flag invalid data to host
// [RQ3] hardware uses nearest lower step, also after nvm reload or restore
// [RQ4] turn-on hardware step spans 2.50 V to 18.25 V in 0.25 V
// [RQ5] turn-off hardware step spans 2.25 V to 18.25 V in 0.25 V
// [RQ6] conversion starts only once sensed input reaches turn-on threshold
// [RQ7] enabled but power stage below turn-off: stop, set low-input status
// [RQ8] low-input fault masked after reset until input first exceeds turn-on
// [RQ9] only power-on reset re-arms the fault mask, nothing else
// [RQ10] host should keep turn-off below turn-on to avoid chatter
// [RQ11] host should avoid switching above 1100 kHz when stacked
// [RQ12] phase register writable only single phase; always readable
// [RQ13] phase register writability fixed by stack setting at power-on
// [RQ14] phase register bits 15:12 always read zero
// [RQ15] fields: group 11:8, count 7:4 in 1..4, slot 3:0 below count
// [RQ16] oscillator lags sync by 360 over count times slot degrees
// [RQ17] linear value decodes as mantissa times two to signed exponent
`timescale 1ns/1ps
`default_nettype none
module ithr_regs
	import ithr_pkg::*;
(
	// clocks and reset
	input  wire logic        clk_sys_i,
	input  wire logic        clk_link_i,
	input  wire logic        arst_n_i,
	// command port, link clock
	input  wire logic        lk_req_i,
	input  wire logic        lk_write_i,
	input  wire logic [7:0]  lk_cmd_i,
	input  wire logic [15:0] lk_wdata_i,
	output logic             lk_busy_o,
	output logic             lk_done_o,
	output logic      [15:0] lk_rdata_o,
	// nvm image and stack strap, system clock
	input  wire logic [10:0] nvm_on_man_i,
	input  wire logic [10:0] nvm_off_man_i,
	input  wire logic [11:0] nvm_ilv_i,
	input  wire logic        stack_multi_i,
	// sensed pins, quarter volts
	input  wire logic [7:0]  vin_sense_i,
	input  wire logic [7:0]  power_stage_input_i,
	input  wire logic        enable_ok_i,
	// converter control and status
	output logic             conv_en_o,
	output logic      [6:0]  on_step_o,
	output logic      [6:0]  off_step_o,
	output logic      [8:0]  phase_deg_o,
	output logic             ilv_writable_o,
	output logic             low_vin_fault_o,
	output logic             unit_off_low_o,
	output logic             alert_o
);
	ithr_sys_s  s_ff;
	ithr_sys_s  nxt_s;
	ithr_link_s l_ff;
	ithr_link_s nxt_l;

	logic [16:0] pins_q;
	logic [7:0]  vin_q;
	logic [7:0]  stage_q;
	logic        en_q;
	logic        req_q;
	logic        ack_q;

	ithr_sync2 #(.W(17)) u_pin_sync (
		.clk_i    (clk_sys_i),
		.arst_n_i (arst_n_i),
		.d_i      ({enable_ok_i, power_stage_input_i, vin_sense_i}),
		.q_o      (pins_q)
	);
	ithr_sync2 #(.W(1)) u_req_sync (
		.clk_i    (clk_sys_i),
		.arst_n_i (arst_n_i),
		.d_i      (l_ff.req_tgl),
		.q_o      (req_q)
	);
	ithr_sync2 #(.W(1)) u_ack_sync (
		.clk_i    (clk_link_i),
		.arst_n_i (arst_n_i),
		.d_i      (s_ff.ack_tgl),
		.q_o      (ack_q)
	);

	assign vin_q   = pins_q[7:0];
	assign stage_q = pins_q[15:8];
	assign en_q    = pins_q[16];

	// linear word to quarter volts, floored
	function automatic ithr_dec_s lin_to_quarter(input ithr_lin_s v);
		ithr_dec_s          r;
		logic signed [31:0] m;
		logic signed [5:0]  sh;
		logic        [4:0]  nsh;
		r   = '0;
		m   = 32'(signed'(v.man));
		sh  = signed'(v.exp[4] ? {1'b1, v.exp} : {1'b0, v.exp}) + QTR_SHIFT; // RQ17
		nsh = 5'(-sh);
		if (sh >= 6'sh00) begin
			r.q = m <<< sh[4:0]; // RQ17
		end else begin
			r.q    = m >>> nsh; // RQ3
			r.frac = |(m & ((32'sh00000001 <<< nsh) - 32'sh00000001));
		end
		return r;
	endfunction
	function automatic logic in_range(input ithr_dec_s d,
		input logic signed [31:0] lo);
		return (d.q >= lo) &&
			((d.q < THR_MAX_Q) || ((d.q == THR_MAX_Q) && !d.frac));
	endfunction
	function automatic logic [6:0] to_step(input ithr_dec_s d,
		input logic signed [31:0] lo);
		logic [6:0] st;
		st = d.q[6:0]; // RQ3
		if (d.q < lo) begin
			st = lo[6:0];
		end else if (d.q > THR_MAX_Q) begin
			st = THR_MAX_Q[6:0];
		end
		return st;
	endfunction
	function automatic logic ilv_ok(input ithr_ilv_s v);
		return (v.count >= CNT_MIN) && (v.count <= CNT_MAX) &&
			(v.slot < v.count); // RQ15
	endfunction
	function automatic logic [8:0] phase_of(input ithr_ilv_s v);
		logic [8:0] step;
		step = (v.count == 4'h4) ? PH_STEP4 :
			(v.count == 4'h3) ? PH_STEP3 :
			(v.count == 4'h2) ? PH_STEP2 : 9'h000;
		return step * {7'h00, v.slot[1:0]}; // RQ16
	endfunction
	ithr_lin_s  wr_lin;
	ithr_ilv_s  wr_ilv;
	ithr_dec_s  wr_dec;
	ithr_dec_s  on_dec;
	ithr_dec_s  off_dec;
	logic       req_edge;
	logic       on_valid;
	logic       off_valid;
	logic       stage_low;
	assign wr_lin    = ithr_lin_s'(l_ff.req.wdata);
	assign wr_ilv    = ithr_ilv_s'(l_ff.req.wdata[GRP_MSB:0]);
	assign wr_dec    = lin_to_quarter(wr_lin);
	assign on_dec    = lin_to_quarter(s_ff.on_thr);
	assign off_dec   = lin_to_quarter(s_ff.off_thr);
	assign req_edge  = (req_q != s_ff.req_seen) && (s_ff.state == ST_RUN);
	assign on_valid  = in_range(wr_dec, ON_MIN_Q); // RQ2
	assign off_valid = in_range(wr_dec, OFF_MIN_Q); // RQ2
	assign stage_low = stage_q < {1'b0, s_ff.off_step};

	// system domain: register file and converter control
	always_comb begin
		nxt_s = s_ff;
		case (s_ff.state)
			ST_LOAD: begin
				nxt_s.on_thr    = {EXP_RST, nvm_on_man_i}; // RQ1
				nxt_s.off_thr   = {EXP_RST, nvm_off_man_i}; // RQ1
				nxt_s.ilv       = ithr_ilv_s'(nvm_ilv_i);
				nxt_s.ilv_wr_ok = !stack_multi_i; // RQ13
				nxt_s.state     = ST_RUN;
			end
			ST_RUN: begin
				if (req_edge) begin
					nxt_s.req_seen = req_q;
					nxt_s.ack_tgl  = ~s_ff.ack_tgl;
					nxt_s.rdata    = 16'h0000;
					case (l_ff.req.cmd)
						CMD_TURN_ON_THR: begin
							nxt_s.rdata = s_ff.on_thr;
							if (l_ff.req.write) begin
								if (on_valid) begin
									nxt_s.on_thr = wr_lin;
								end else begin
									nxt_s.sts_invalid = 1'b1; // RQ2
								end
							end
						end
						CMD_TURN_OFF_THR: begin
							nxt_s.rdata = s_ff.off_thr;
							if (l_ff.req.write) begin
								if (off_valid) begin
									nxt_s.off_thr = wr_lin;
								end else begin
									nxt_s.sts_invalid = 1'b1; // RQ2
								end
							end
						end
						CMD_PHASE_POS: begin
							nxt_s.rdata = {4'h0, s_ff.ilv}; // RQ14
							if (l_ff.req.write && s_ff.ilv_wr_ok) begin // RQ12
								if (ilv_ok(wr_ilv)) begin
									nxt_s.ilv = wr_ilv;
								end else begin
									nxt_s.sts_invalid = 1'b1;
								end
							end
						end
						CMD_STS_INPUT: begin
							nxt_s.rdata[STS_LOW_OFF_BIT] = s_ff.sts_low_off;
							nxt_s.rdata[STS_UV_BIT]      = s_ff.sts_uv;
						end
						CMD_STS_CML: begin
							nxt_s.rdata[STS_INVALID_BIT] = s_ff.sts_invalid;
						end
						CMD_CLEAR_STATUS: begin
							if (l_ff.req.write) begin
								nxt_s.sts_low_off = 1'b0;
								nxt_s.sts_uv      = 1'b0;
								nxt_s.sts_invalid = 1'b0;
							end
						end
						CMD_RESTORE_ALL: begin
							// reload keeps mask and writability
							if (l_ff.req.write) begin
								nxt_s.on_thr  = {EXP_RST, nvm_on_man_i}; // RQ3
								nxt_s.off_thr = {EXP_RST, nvm_off_man_i}; // RQ3
								nxt_s.ilv     = ithr_ilv_s'(nvm_ilv_i);
							end
						end
						default: begin
							nxt_s.rdata = 16'h0000;
						end
					endcase
				end
				// conversion control
				if (!en_q) begin
					nxt_s.conv = 1'b0;
				end else if (s_ff.conv && stage_low) begin
					nxt_s.conv = 1'b0; // RQ7
				end else if (!s_ff.conv && !stage_low &&
					(vin_q >= {1'b0, s_ff.on_step})) begin
					nxt_s.conv = 1'b1; // RQ6
				end
				// hardware sets win over a clear in the same cycle
				if (en_q && stage_low) begin
					nxt_s.sts_low_off = 1'b1; // RQ7
				end
				if (!s_ff.mask && stage_low) begin
					nxt_s.sts_uv = 1'b1; // RQ8
				end
				if (s_ff.mask && (vin_q > {1'b0, s_ff.on_step})) begin
					nxt_s.mask = 1'b0; // RQ8
				end
			end
			default: begin
				nxt_s.state = ST_LOAD;
			end
		endcase
		nxt_s.on_step   = to_step(on_dec, ON_MIN_Q); // RQ4
		nxt_s.off_step  = to_step(off_dec, OFF_MIN_Q); // RQ5
		nxt_s.phase_deg = phase_of(s_ff.ilv); // RQ16
		nxt_s.alert     = nxt_s.sts_low_off | nxt_s.sts_uv |
			nxt_s.sts_invalid; // RQ2
	end
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_ff          <= '0;
			s_ff.state    <= ST_LOAD;
			s_ff.on_thr   <= {EXP_RST, 11'h000};
			s_ff.off_thr  <= {EXP_RST, 11'h000};
			s_ff.ilv      <= {4'h0, CNT_MIN, 4'h0};
			s_ff.mask     <= 1'b1; // RQ8
			s_ff.on_step  <= ON_MIN_Q[6:0];
			s_ff.off_step <= OFF_MIN_Q[6:0];
		end else begin
			s_ff <= nxt_s;
		end
	end

	// link domain: take request, hand over, return answer
	always_comb begin
		nxt_l      = l_ff;
		nxt_l.done = 1'b0;
		if (!l_ff.busy && lk_req_i) begin
			nxt_l.req     = {lk_write_i, lk_cmd_i, lk_wdata_i};
			nxt_l.busy    = 1'b1;
			nxt_l.req_tgl = ~l_ff.req_tgl;
		end
		if (l_ff.busy && (ack_q != l_ff.ack_seen)) begin
			nxt_l.ack_seen = ack_q;
			nxt_l.rdata    = s_ff.rdata;
			nxt_l.done     = 1'b1;
			nxt_l.busy     = 1'b0;
		end
	end
	always_ff @(posedge clk_link_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			l_ff <= '0;
		end else begin
			l_ff <= nxt_l;
		end
	end
	assign lk_busy_o       = l_ff.busy;
	assign lk_done_o       = l_ff.done;
	assign lk_rdata_o      = l_ff.rdata;
	assign conv_en_o       = s_ff.conv;
	assign on_step_o       = s_ff.on_step;
	assign off_step_o      = s_ff.off_step;
	assign phase_deg_o     = s_ff.phase_deg;
	assign ilv_writable_o  = s_ff.ilv_wr_ok;
	assign low_vin_fault_o = s_ff.sts_uv;
	assign unit_off_low_o  = s_ff.sts_low_off;
	assign alert_o         = s_ff.alert;

	a_conv_start_on: assert property ( // RQ6
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		$rose(s_ff.conv) |-> ($past(vin_q) >= {1'b0, $past(s_ff.on_step)}))
		else $error("conversion started below turn-on level");
	a_low_off_flag: assert property ( // RQ7
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(s_ff.state == ST_RUN && en_q && stage_low)
		|=> (s_ff.sts_low_off && !s_ff.conv && alert_o))
		else $error("low input did not stop conversion or flag");
	a_mask_holds: assert property ( // RQ8
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		$rose(s_ff.sts_uv) |-> !$past(s_ff.mask))
		else $error("low input fault raised while masked");
	a_mask_no_rearm: assert property ( // RQ9
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		!s_ff.mask |=> !s_ff.mask)
		else $error("fault mask re-armed without reset");
	a_mask_clears: assert property ( // RQ8
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(s_ff.state == ST_RUN && s_ff.mask &&
			vin_q > {1'b0, s_ff.on_step}) |=> !s_ff.mask)
		else $error("fault mask kept after input exceeded turn-on");
	a_bad_write_flag: assert property ( // RQ2
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(req_edge && l_ff.req.write && l_ff.req.cmd == CMD_TURN_ON_THR &&
			!on_valid) |=> (s_ff.sts_invalid && $stable(s_ff.on_thr)))
		else $error("invalid turn-on write not refused");
	a_step_ranges: assert property ( // RQ4
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		s_ff.state == ST_RUN |-> (s_ff.on_step >= ON_MIN_Q[6:0] &&
			s_ff.on_step <= THR_MAX_Q[6:0] &&
			s_ff.off_step >= OFF_MIN_Q[6:0] &&
			s_ff.off_step <= THR_MAX_Q[6:0]))
		else $error("hardware step outside supported span");
	a_ilv_read_only: assert property ( // RQ12
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(s_ff.state == ST_RUN && !s_ff.ilv_wr_ok &&
			!(req_edge && l_ff.req.cmd == CMD_RESTORE_ALL))
		|=> $stable(s_ff.ilv))
		else $error("phase register changed while stacked");
	a_wr_ok_frozen: assert property ( // RQ13
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		s_ff.state == ST_RUN |=> $stable(s_ff.ilv_wr_ok))
		else $error("phase writability changed after power-on");
	a_ilv_top_zero: assert property ( // RQ14
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(req_edge && l_ff.req.cmd == CMD_PHASE_POS)
		|=> (s_ff.rdata == {4'h0, $past(s_ff.ilv)}))
		else $error("phase register read word wrong or upper bits set");
	a_phase_quarter: assert property ( // RQ16
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(s_ff.ilv.count == 4'h4 && s_ff.ilv.slot == 4'h3)
		|=> s_ff.phase_deg == 9'h10e)
		else $error("four-phase slot three not at 270 degrees");
	a_link_answer: assert property (
		@(posedge clk_link_i) disable iff (!arst_n_i)
		lk_done_o |-> (!lk_busy_o && $past(lk_busy_o)))
		else $error("answer without pending request");
endmodule
`default_nettype wire

// ==== design/ithr_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module ithr_sync2
	import ithr_pkg::*;
#(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	// data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ithr_sync_s;

	ithr_sync_s s_ff;
	ithr_sync_s nxt_s;

	always_comb begin
		nxt_s    = s_ff;
		nxt_s.s1 = d_i;
		nxt_s.s2 = s_ff.s1;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign q_o = s_ff.s2;
endmodule
`default_nettype wire

// ==== test/ithr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module ithr_host (
	// link clock
	input  wire logic        clk_link_i,
	// command port
	output var  logic        lk_req_o,
	output var  logic        lk_write_o,
	output var  logic [7:0]  lk_cmd_o,
	output var  logic [15:0] lk_wdata_o,
	input  wire logic        lk_busy_i,
	input  wire logic        lk_done_i,
	input  wire logic [15:0] lk_rdata_i
);
	initial begin
		lk_req_o   = 1'b0;
		lk_write_o = 1'b0;
		lk_cmd_o   = 8'h00;
		lk_wdata_o = 16'h0000;
	end

	// one whole word per request, one request outstanding
	task automatic xfer(input logic wr, input logic [7:0] c,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		q = 16'hxxxx;
		@(posedge clk_link_i);
		lk_req_o   <= 1'b1;
		lk_write_o <= wr;
		lk_cmd_o   <= c;
		lk_wdata_o <= d;
		@(posedge clk_link_i);
		while (lk_busy_i !== 1'b0 && n < 64) begin
			@(posedge clk_link_i);
			n++;
		end
		lk_req_o   <= 1'b0;
		// released lines never show the last value
		lk_write_o <= ~wr;
		lk_cmd_o   <= ~c;
		lk_wdata_o <= ~d;
		while (lk_done_i !== 1'b1 && n < 64) begin
			@(posedge clk_link_i);
			n++;
		end
		if (lk_done_i === 1'b1) begin
			q = lk_rdata_i;
		end
	endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
	import ithr_pkg::*;
;
	logic        clk_sys, clk_link, arst_n, req, wr_l, busy, done;
	logic        stack, en, conv, wrable, fault, uoff, alert, sel, ok;
	logic [7:0]  cmd, vin, stage, c;
	logic [15:0] wdata, rdata, q, w;
	logic [10:0] on_man, off_man;
	logic [11:0] ilv;
	logic [6:0]  on_st, off_st, st;
	logic [8:0]  deg;
	logic [24:0] tab [10];
	logic [7:0]  ph [6];
	logic [15:0] cur [2];
	int          err_count = 0;
	int          compares = 0;
	int          cyc = 0;

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		clk_link = 1'b0;
		#7;
		forever #24 clk_link = ~clk_link;
	end

	ithr_regs u_dut (
		.clk_sys_i(clk_sys), .clk_link_i(clk_link), .arst_n_i(arst_n),
		.lk_req_i(req), .lk_write_i(wr_l), .lk_cmd_i(cmd),
		.lk_wdata_i(wdata), .lk_busy_o(busy), .lk_done_o(done),
		.lk_rdata_o(rdata), .nvm_on_man_i(on_man),
		.nvm_off_man_i(off_man), .nvm_ilv_i(ilv),
		.stack_multi_i(stack), .vin_sense_i(vin),
		.power_stage_input_i(stage), .enable_ok_i(en),
		.conv_en_o(conv), .on_step_o(on_st), .off_step_o(off_st),
		.phase_deg_o(deg), .ilv_writable_o(wrable),
		.low_vin_fault_o(fault), .unit_off_low_o(uoff), .alert_o(alert)
	);

	ithr_host u_host (
		.clk_link_i(clk_link), .lk_req_o(req), .lk_write_o(wr_l),
		.lk_cmd_o(cmd), .lk_wdata_o(wdata), .lk_busy_i(busy),
		.lk_done_i(done), .lk_rdata_i(rdata)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic flags(input logic [2:0] e);
		chk({13'h0000, conv, uoff, fault}, {13'h0000, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		u_host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		u_host.xfer(1'b0, a, 16'h0000, q);
	endtask
	task automatic pins(input logic [7:0] v, input logic [7:0] s,
		input logic e);
		@(posedge clk_sys);
		vin   <= v;
		stage <= s;
		en    <= e;
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic do_reset(input logic m);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		stack  <= m;
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic test_done;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			test_done();
		end
	end

	initial begin
		arst_n  = 1'b0;
		stack   = 1'b0;
		en      = 1'b0;
		vin     = 8'h00;
		stage   = 8'h00;
		on_man  = 11'h028;
		off_man = 11'h024;
		ilv     = 12'h543;
		// {off, accepted, step, word}; turn-off kept below turn-on
		tab = '{{1'b0, 1'b1, 7'h49, 16'hf049}, {1'b0, 1'b0, 7'h49, 16'hf04a},
			{1'b1, 1'b1, 7'h09, 16'hf009}, {1'b1, 1'b0, 7'h09, 16'hf008},
			{1'b0, 1'b1, 7'h0a, 16'hf00a}, {1'b0, 1'b0, 7'h0a, 16'hf009},
			{1'b0, 1'b1, 7'h29, 16'he853}, {1'b1, 1'b1, 7'h26, 16'hf813},
			{1'b1, 1'b0, 7'h26, 16'hf825}, {1'b0, 1'b1, 7'h48, 16'h0809}};
		ph  = '{8'h10, 8'h21, 8'h31, 8'h32, 8'h41, 8'h43};
		cur = '{16'hf028, 16'hf024};
		do_reset(1'b0);
		rd(CMD_TURN_ON_THR);
		chk(q, 16'hf028);
		rd(CMD_TURN_OFF_THR);
		chk(q, 16'hf024);
		rd(CMD_PHASE_POS);
		chk(q, 16'h0543);
		chk({7'h00, deg}, 16'h010e);
		chk({9'h000, on_st}, 16'h0028);
		chk({9'h000, off_st}, 16'h0024);
		chk({15'h0000, wrable}, 16'h0001);
		rd(8'h50);
		chk(q, 16'h0000);
		// only threshold and status commands are issued
		for (int i = 0; i < 10; i++) begin
			{sel, ok, st, w} = tab[i];
			c = sel ? CMD_TURN_OFF_THR : CMD_TURN_ON_THR;
			wr(c, w);
			if (ok) begin
				cur[sel] = w;
			end
			rd(c);
			chk(q, cur[sel]);
			chk({15'h0000, alert}, {15'h0000, ~ok});
			rd(CMD_STS_CML);
			chk(q & 16'h0040, ok ? 16'h0000 : 16'h0040);
			chk({9'h000, sel ? off_st : on_st}, {9'h000, st});
			wr(CMD_CLEAR_STATUS, 16'h0000);
		end
		wr(CMD_RESTORE_ALL, 16'h0000);
		rd(CMD_TURN_ON_THR);
		chk(q, 16'hf028);
		chk({9'h000, off_st}, 16'h0024);
		pins(8'h27, 8'h3c, 1'b1);
		flags(3'b000);
		pins(8'h28, 8'h1e, 1'b1);
		flags(3'b010);
		pins(8'h28, 8'h3c, 1'b1);
		wr(CMD_CLEAR_STATUS, 16'h0000);
		flags(3'b100);
		pins(8'h28, 8'h1e, 1'b1);
		flags(3'b010);
		pins(8'h29, 8'h3c, 1'b1);
		wr(CMD_CLEAR_STATUS, 16'h0000);
		flags(3'b100);
		pins(8'h29, 8'h1e, 1'b1);
		flags(3'b011);
		rd(CMD_STS_INPUT);
		chk(q & 16'h0018, 16'h0018);
		pins(8'h00, 8'h3c, 1'b0);
		pins(8'h00, 8'h3c, 1'b1);
		wr(CMD_CLEAR_STATUS, 16'h0000);
		wr(CMD_RESTORE_ALL, 16'h0000);
		flags(3'b000);
		pins(8'h00, 8'h1e, 1'b1);
		flags(3'b011);
		pins(8'h00, 8'h3c, 1'b0);
		// legal count and slot pairs, top nibble set on purpose
		for (int i = 0; i < 6; i++) begin
			w = {4'hf, i[3:0], ph[i]};
			wr(CMD_PHASE_POS, w);
			rd(CMD_PHASE_POS);
			chk(q, {4'h0, w[11:0]});
			chk({7'h00, deg}, 16'(360 / ph[i][7:4] * ph[i][3:0]));
		end
		wr(CMD_PHASE_POS, 16'h0050);
		wr(CMD_PHASE_POS, 16'h0022);
		rd(CMD_PHASE_POS);
		chk(q, 16'h0543);
		chk({15'h0000, alert}, 16'h0001);
		do_reset(1'b1);
		@(posedge clk_sys);
		stack <= 1'b0;
		repeat (8) @(posedge clk_sys);
		chk({15'h0000, wrable}, 16'h0000);
		wr(CMD_PHASE_POS, 16'h0010);
		rd(CMD_PHASE_POS);
		chk(q, 16'h0543);
		chk({15'h0000, alert}, 16'h0000);
		chk({7'h00, deg}, 16'h010e);
		test_done();
	end
endmodule
`default_nettype wire
